// *** logic/udc_counter.sv ***
// Purpose: Up/down pulse counter with threshold-driven switching output
// Assumes: Pins are asynchronous and pass two flip-flops; live thresholds come from same-clock logic
// Notes:   Register port answers reads one cycle later; unmapped reads return zero
`default_nettype none
module udc_counter (
  // Clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  // Register port
  input  wire logic [udc_pkg::ADDR_W-1:0]          addr_in,
  input  wire logic [udc_pkg::DATA_W-1:0]          wdata_in,
  input  wire logic                                wr_in,
  input  wire logic                                rd_in,
  output logic      [udc_pkg::DATA_W-1:0]          rdata_out,
  // Circuit inputs, asynchronous
  input  wire logic                                fast_pulse_pins_in,
  input  wire logic                                dir_in,
  input  wire logic                                count_clear_in,
  input  wire logic                                power_fail_in,
  // Live threshold sources, same clock
  input  wire logic signed [udc_pkg::EXT_W-1:0]    on_ext_in,
  input  wire logic signed [udc_pkg::EXT_W-1:0]    off_ext_in,
  // Results
  output logic                                     switch_out,
  output logic      [udc_pkg::CNT_W-1:0]           count_out
);
  // ==========================================================
  // Pin synchronisers
  localparam int unsigned P_PULSE = 0;
  localparam int unsigned P_DIR   = 1;
  localparam int unsigned P_CLEAR = 2;
  localparam int unsigned P_PFAIL = 3;

  logic [udc_pkg::SYNC_N-1:0] pin_level;
  logic [udc_pkg::SYNC_N-1:0] pin_rise;

  // One shared synchroniser, so all four pins age alike
  udc_sync_edge #(
    .N         (udc_pkg::SYNC_N)
  ) u_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    ({power_fail_in, count_clear_in, dir_in, fast_pulse_pins_in}),
    .level_out (pin_level),
    .rise_out  (pin_rise)
  );

  logic pulse_rise;
  logic dir_down;
  logic clear_hold;
  logic pfail_hold;
  logic pfail_rise;

  assign pulse_rise = pin_rise[P_PULSE];
  assign dir_down   = pin_level[P_DIR];
  assign clear_hold = pin_level[P_CLEAR];
  assign pfail_hold = pin_level[P_PFAIL];
  assign pfail_rise = pin_rise[P_PFAIL];

  // ==========================================================
  // Control registers
  logic [udc_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [udc_pkg::CNT_W-1:0]  on_q, on_d;
  logic [udc_pkg::CNT_W-1:0]  off_q, off_d;

  // Out-of-range writes clamp rather than drop, so software
  // never loses a threshold write without trace
  function automatic logic [udc_pkg::CNT_W-1:0] clamp_wr(input logic [udc_pkg::DATA_W-1:0] v);
    logic [udc_pkg::CNT_W-1:0] r;
    r = udc_pkg::THR_MAX;
    if (v <= {12'h000, udc_pkg::THR_MAX}) begin
      r = v[udc_pkg::CNT_W-1:0];
    end
    return r;
  endfunction

  always_comb begin
    ctrl_d = ctrl_q;
    on_d   = on_q;
    off_d  = off_q;
    if (wr_in) begin
      unique case (addr_in)
        udc_pkg::OFS_CTRL: begin
          ctrl_d = wdata_in[udc_pkg::CTRL_W-1:0];
        end
        udc_pkg::OFS_ON: begin
          on_d = clamp_wr(wdata_in);
        end
        udc_pkg::OFS_OFF: begin
          off_d = clamp_wr(wdata_in);
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q <= udc_pkg::CTRL_RST;
      on_q   <= udc_pkg::ON_RST;
      off_q  <= udc_pkg::OFF_RST;
    end else begin
      ctrl_q <= ctrl_d;
      on_q   <= on_d;
      off_q  <= off_d;
    end
  end

  // Retention spares the count only; the output still drops
  logic retain;
  assign retain = ctrl_q[udc_pkg::CTRL_RETAIN];

  // ==========================================================
  // Scan cycle timer
  // Fixed period, not writable, so software cannot stretch
  // the scan under a running count
  localparam logic [udc_pkg::SCAN_W-1:0] SCAN_LAST = udc_pkg::SCAN_W'(udc_pkg::SCAN_CYCLES - 1);

  logic [udc_pkg::SCAN_W-1:0] scan_q, scan_d;
  logic                       scan_tick;

  always_comb begin
    scan_tick = (scan_q == SCAN_LAST);
    scan_d    = scan_tick ? '0 : scan_q + 12'h001;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scan_q <= '0;
    end else begin
      scan_q <= scan_d;
    end
  end

  // ==========================================================
  // Count state
  // Saturates at the range ends rather than wrapping, so a stray
  // extra edge never flips a high count to zero.
  logic [udc_pkg::CNT_W-1:0] count_q, count_d;
  logic                      step_en;
  logic                      lose_count;
  logic                      at_top;
  logic                      at_bottom;

  // Edges seen while the supply fails are dropped: the pin
  // may glitch as the rail falls
  always_comb begin
    step_en    = pulse_rise && !pfail_hold;
    lose_count = pfail_rise && !retain;
    at_top     = (count_q == udc_pkg::THR_MAX);
    at_bottom  = (count_q == udc_pkg::CNT_ZERO);
  end

  always_comb begin
    count_d = count_q;
    if (clear_hold) begin
      count_d = udc_pkg::CNT_ZERO;
    end else if (lose_count) begin
      count_d = udc_pkg::CNT_ZERO;
    end else if (step_en) begin
      if (!dir_down) begin
        if (!at_top) begin
          count_d = count_q + udc_pkg::CNT_ONE;
        end
      end else begin
        if (!at_bottom) begin
          count_d = count_q - udc_pkg::CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_q <= udc_pkg::CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================
  // Threshold evaluation
  // Live thresholds come from same-clock logic, so they need
  // no synchroniser
  udc_eval_if ev ();

  logic q_q, q_d;
  logic q_eval;

  assign ev.count       = count_q;
  assign ev.on_fix      = on_q;
  assign ev.off_fix     = off_q;
  assign ev.on_ext      = on_ext_in;
  assign ev.off_ext     = off_ext_in;
  assign ev.on_sel_ext  = ctrl_q[udc_pkg::CTRL_ON_EXT];
  assign ev.off_sel_ext = ctrl_q[udc_pkg::CTRL_OFF_EXT];
  assign ev.q_prev      = q_q;

  udc_thresh_eval u_eval (
    .ev (ev.eval)
  );

  // The evaluator settles every cycle; only the tick lets its
  // answer through, which is what allows overshoot
  always_comb begin
    q_eval = scan_tick ? ev.q_next : q_q;
  end

  always_comb begin
    q_d = q_eval;
    if (clear_hold) begin
      q_d = 1'b0;
    end else if (pfail_hold) begin
      q_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_q <= 1'b0;
    end else begin
      q_q <= q_d;
    end
  end

  // ==========================================================
  // Register read port
  logic [udc_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic [udc_pkg::DATA_W-1:0] status_w;

  always_comb begin
    status_w = '0;
    status_w[udc_pkg::STAT_Q]     = q_q;
    status_w[udc_pkg::STAT_CLEAR] = clear_hold;
    status_w[udc_pkg::STAT_PFAIL] = pfail_hold;
  end

  // Idle reads return zero so a stuck strobe shows at once
  always_comb begin
    rdata_d = '0;
    if (rd_in) begin
      unique case (addr_in)
        udc_pkg::OFS_CTRL: begin
          rdata_d = {29'h00000000, ctrl_q};
        end
        udc_pkg::OFS_ON: begin
          rdata_d = {12'h000, ev.on_eff};
        end
        udc_pkg::OFS_OFF: begin
          rdata_d = {12'h000, ev.off_eff};
        end
        udc_pkg::OFS_COUNT: begin
          rdata_d = {12'h000, count_q};
        end
        udc_pkg::OFS_STATUS: begin
          rdata_d = status_w;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign rdata_out  = rdata_q;
  assign switch_out = q_q;
  assign count_out  = count_q;
endmodule : udc_counter
`default_nettype wire

// *** pkg/udc_pkg.sv ***
// Purpose: Shared constants for the up/down threshold counter
// Assumes: 250 MHz core clock, plain register port
// Notes:   Counts and thresholds are six decimal digits wide in range
`default_nettype none
package udc_pkg;
  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CNT_W    = 20;
  localparam int unsigned EXT_W    = 32;
  localparam int unsigned SYNC_N   = 4;

  // ==========================================================
  // Value range
  localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
  localparam logic [CNT_W-1:0] THR_MAX  = 20'hF423F;
  localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned SCAN_PERIOD_NS = 1000;
  localparam int unsigned SCAN_CYCLES    = (SCAN_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int unsigned SCAN_W         = 12;

  // ==========================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ON     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OFF    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

  // ==========================================================
  // Control fields
  localparam int unsigned CTRL_RETAIN  = 0;
  localparam int unsigned CTRL_ON_EXT  = 1;
  localparam int unsigned CTRL_OFF_EXT = 2;
  localparam int unsigned CTRL_W       = 3;

  // ==========================================================
  // Status fields
  localparam int unsigned STAT_Q       = 0;
  localparam int unsigned STAT_CLEAR   = 1;
  localparam int unsigned STAT_PFAIL   = 2;

  // ==========================================================
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [CNT_W-1:0]  ON_RST   = 20'h00000;
  localparam logic [CNT_W-1:0]  OFF_RST  = 20'h00000;
endpackage : udc_pkg
`default_nettype wire

// *** pkg/udc_eval_if.sv ***
// Purpose: Carries count, thresholds and output state to the evaluator
// Assumes: Single clock domain
// Notes:   ctrl drives inputs, eval returns the clamped thresholds and next output
`default_nettype none
interface udc_eval_if;
  logic [udc_pkg::CNT_W-1:0]        count;
  logic [udc_pkg::CNT_W-1:0]        on_fix;
  logic [udc_pkg::CNT_W-1:0]        off_fix;
  logic signed [udc_pkg::EXT_W-1:0] on_ext;
  logic signed [udc_pkg::EXT_W-1:0] off_ext;
  logic                             on_sel_ext;
  logic                             off_sel_ext;
  logic                             q_prev;
  logic [udc_pkg::CNT_W-1:0]        on_eff;
  logic [udc_pkg::CNT_W-1:0]        off_eff;
  logic                             q_next;

  modport ctrl (
    output count, on_fix, off_fix, on_ext, off_ext, on_sel_ext, off_sel_ext, q_prev,
    input  on_eff, off_eff, q_next
  );
  modport eval (
    input  count, on_fix, off_fix, on_ext, off_ext, on_sel_ext, off_sel_ext, q_prev,
    output on_eff, off_eff, q_next
  );
endinterface : udc_eval_if
`default_nettype wire

// *** logic/udc_sync_edge.sv ***
// Purpose: Two-stage synchroniser with rising-edge detect per pin
// Assumes: Inputs asynchronous to clk_in
// Notes:   First stage is read only by the second
`default_nettype none
module udc_sync_edge #(
  parameter int unsigned N = 4
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Pins
  input  wire logic [N-1:0] pin_in,
  // Synchronised view
  output logic      [N-1:0] level_out,
  output logic      [N-1:0] rise_out
);
  logic [N-1:0] meta_q, meta_d;
  logic [N-1:0] sync_q, sync_d;
  logic [N-1:0] last_q, last_d;

  // ==========================================================
  // Per-pin stages
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_comb begin
        meta_d[i] = pin_in[i];
        sync_d[i] = meta_q[i];
        last_d[i] = sync_q[i];
        rise_out[i] = sync_q[i] & ~last_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level_out = sync_q;
endmodule : udc_sync_edge
`default_nettype wire

// *** logic/udc_thresh_eval.sv ***
// Purpose: Threshold source select, clamping and switching decision
// Assumes: Purely combinational, sampled by the caller once per scan
// Notes:   External values are signed and may lie far outside range
`default_nettype none
module udc_thresh_eval (
  // Evaluation link
  udc_eval_if.eval ev
);
  // ==========================================================
  // Clamp into the legal threshold range
  function automatic logic [udc_pkg::CNT_W-1:0] clamp_ext(input logic signed [udc_pkg::EXT_W-1:0] v);
    logic [udc_pkg::CNT_W-1:0] r;
    r = udc_pkg::CNT_ZERO;
    if (v < 0) begin
      r = udc_pkg::CNT_ZERO;
    end else if (v > $signed({12'h000, udc_pkg::THR_MAX})) begin
      r = udc_pkg::THR_MAX;
    end else begin
      r = v[udc_pkg::CNT_W-1:0];
    end
    return r;
  endfunction

  always_comb begin
    ev.on_eff  = ev.on_sel_ext  ? clamp_ext(ev.on_ext)  : ev.on_fix;
    ev.off_eff = ev.off_sel_ext ? clamp_ext(ev.off_ext) : ev.off_fix;
    ev.q_next  = ev.q_prev;
    if (ev.on_eff >= ev.off_eff) begin
      if (ev.count >= ev.on_eff) begin
        ev.q_next = 1'b1;
      end else if (ev.count < ev.off_eff) begin
        ev.q_next = 1'b0;
      end else begin
        ev.q_next = ev.q_prev;
      end
    end else begin
      ev.q_next = (ev.count >= ev.on_eff) && (ev.count < ev.off_eff);
    end
  end
endmodule : udc_thresh_eval
`default_nettype wire

// *** dv/udc_counter_chk.sv ***
// Purpose: Port-level checks of the up/down threshold counter
// Assumes: Scan tick every SCAN_CYCLES edges from reset release
// Notes:   Bound into udc_counter at the foot of this file
`default_nettype none
module udc_counter_chk (
  input wire logic                       clk_in,
  input wire logic                       rst_in,
  input wire logic [udc_pkg::ADDR_W-1:0] addr_in,
  input wire logic                       rd_in,
  input wire logic [udc_pkg::DATA_W-1:0] rdata_out,
  input wire logic                       fast_pulse_pins_in,
  input wire logic                       dir_in,
  input wire logic                       count_clear_in,
  input wire logic                       power_fail_in,
  input wire logic                       switch_out,
  input wire logic [udc_pkg::CNT_W-1:0]  count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================================
  // Scan phase, slack of two edges for output registering
  logic [udc_pkg::SCAN_W-1:0] sc_q;
  logic [udc_pkg::SCAN_W-1:0] sc_d;
  always_comb begin
    sc_d = (sc_q == udc_pkg::SCAN_W'(udc_pkg::SCAN_CYCLES - 1)) ? 12'h000 : sc_q + 12'h001;
    if (rst_in) sc_d = 12'h000;
  end
  always_ff @(posedge clk_in) sc_q <= sc_d;
  // ==========================================================
  // Sequences
  sequence clr_held; count_clear_in [*4]; endsequence
  sequence pf_held; power_fail_in [*5]; endsequence
  sequence rd_at(a); rd_in && addr_in == a; endsequence
  // ==========================================================
  // Assertions
  clear_zero_a: assert property (clr_held |-> count_out == udc_pkg::CNT_ZERO && !switch_out)
    else $error("count or switch not cleared under clear");
  step_one_a: assert property (!$stable(count_out) |-> count_out == $past(count_out) + 20'h00001 ||
    count_out == $past(count_out) - 20'h00001 || count_out == 20'h00000) else $error("count jumped");
  dir_sense_a: assert property (!$stable(count_out) && count_out != 20'h00000 |->
    (count_out > $past(count_out)) == !$past(dir_in, 3)) else $error("count moved against direction");
  scan_rise_a: assert property ($rose(switch_out) |-> sc_q <= 12'h002)
    else $error("switch rose off the scan tick");
  pf_low_a: assert property (pf_held |-> !switch_out)
    else $error("switch high during power loss");
  cnt_range_a: assert property (count_out <= udc_pkg::THR_MAX)
    else $error("count beyond range");
  rd_idle_a: assert property (!rd_in |=> rdata_out == 32'h00000000)
    else $error("read data not zero when idle");
  rd_count_a: assert property (rd_at(udc_pkg::OFS_COUNT) |=> rdata_out == 32'($past(count_out)))
    else $error("count read mismatch");
  rd_stat_a: assert property (rd_at(udc_pkg::OFS_STATUS) |=> rdata_out[udc_pkg::STAT_Q] == $past(switch_out))
    else $error("status switch bit mismatch");
  rd_gap_a: assert property (rd_at(8'h14) |=> rdata_out == 32'h00000000)
    else $error("unmapped read not zero");
endmodule // udc_counter_chk
bind udc_counter udc_counter_chk i_chk (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .fast_pulse_pins_in(fast_pulse_pins_in), .dir_in(dir_in),
  .count_clear_in(count_clear_in), .power_fail_in(power_fail_in), .switch_out(switch_out), .count_out(count_out));
`default_nettype wire

// *** dv/udc_circuit_model.sv ***
// Purpose: Circuit logic driving pulse, direction, clear and power loss
// Assumes: Same clock as the counter
// Notes:   Direction settles four cycles before any edge
`default_nettype none
module udc_circuit_model (
  input  wire logic clk_in,
  output logic      pulse_out,
  output logic      dir_out,
  output logic      clear_out,
  output logic      pfail_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pulse_out = 1'b0;
    dir_out   = 1'b0;
    clear_out = 1'b0;
    pfail_out = 1'b0;
  end
  task automatic pulses(input int n, input logic down);
    @(posedge clk_in) dir_out <= down;
    repeat (4) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      pulse_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      pulse_out <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask
  task automatic level(input logic clr, input logic pf);
    @(posedge clk_in) clear_out <= clr;
    pfail_out <= pf;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // udc_circuit_model
`default_nettype wire

// *** dv/udc_counter_tb.sv ***
// Purpose: Self-checking bench for the up/down threshold counter
// Assumes: Scan tick every 250 cycles, so 260 covers one
// Notes:   Checker is bound in from its own file
`default_nettype none
module udc_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk_in, rst_in, wr_in, rd_in;
  logic [udc_pkg::ADDR_W-1:0] addr_in;
  logic [udc_pkg::DATA_W-1:0] wdata_in, rdata_out;
  logic                       pin, dir, clr, pf, switch_out;
  logic signed [31:0]         on_ext_in, off_ext_in;
  logic [udc_pkg::CNT_W-1:0]  count_out;
  int                         miscompares, compares;
  udc_counter i_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .fast_pulse_pins_in(pin), .dir_in(dir), .count_clear_in(clr),
    .power_fail_in(pf), .on_ext_in(on_ext_in), .off_ext_in(off_ext_in), .switch_out(switch_out),
    .count_out(count_out));
  udc_circuit_model i_ckt (.clk_in(clk_in), .pulse_out(pin), .dir_out(dir), .clear_out(clr), .pfail_out(pf));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in) wr_in <= 1'b1;
    addr_in  <= a;
    wdata_in <= d;
    @(posedge clk_in) wr_in <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    @(posedge clk_in) rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in) rd_in <= 1'b0;
    #1 d = rdata_out;
    chk(n, d, e);
  endtask
  task automatic sw(input logic e);
    repeat (260) @(posedge clk_in);
    #1 chk("switch", {31'h0, switch_out}, {31'h0, e});
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rchk("ctrl", udc_pkg::OFS_CTRL, 32'h0);
    rchk("gap", 8'h14, 32'h0);
    wr(udc_pkg::OFS_ON, 32'hFFFFF);
    rchk("on clamp", udc_pkg::OFS_ON, 32'h000F423F);
    wr(udc_pkg::OFS_COUNT, 32'h5);
    rchk("count ro", udc_pkg::OFS_COUNT, 32'h0);
  endtask
  task automatic t_count;
    i_ckt.pulses(3, 1'b0);
    rchk("up", udc_pkg::OFS_COUNT, 32'h3);
    i_ckt.pulses(1, 1'b1);
    rchk("down", udc_pkg::OFS_COUNT, 32'h2);
  endtask
  task automatic t_hyst;
    wr(udc_pkg::OFS_ON, 32'h5);
    wr(udc_pkg::OFS_OFF, 32'h2);
    i_ckt.pulses(3, 1'b0);
    sw(1'b1);
    i_ckt.pulses(2, 1'b1);
    sw(1'b1);
    i_ckt.pulses(2, 1'b1);
    sw(1'b0);
  endtask
  task automatic t_window;
    wr(udc_pkg::OFS_ON, 32'h2);
    wr(udc_pkg::OFS_OFF, 32'h4);
    i_ckt.pulses(2, 1'b0);
    sw(1'b1);
    i_ckt.pulses(1, 1'b0);
    sw(1'b0);
  endtask
  task automatic t_clear;
    i_ckt.pulses(1, 1'b1);
    sw(1'b1);
    i_ckt.level(1'b1, 1'b0);
    #1 chk("clr switch", {31'h0, switch_out}, 32'h0);
    i_ckt.pulses(2, 1'b0);
    rchk("held", udc_pkg::OFS_COUNT, 32'h0);
    rchk("stat clr", udc_pkg::OFS_STATUS, 32'h2);
    i_ckt.level(1'b0, 1'b0);
    rchk("cleared", udc_pkg::OFS_COUNT, 32'h0);
  endtask
  task automatic t_pfail;
    i_ckt.pulses(3, 1'b0);
    i_ckt.level(1'b0, 1'b1);
    i_ckt.level(1'b0, 1'b0);
    rchk("lost", udc_pkg::OFS_COUNT, 32'h0);
    wr(udc_pkg::OFS_CTRL, 32'h1);
    i_ckt.pulses(2, 1'b0);
    i_ckt.level(1'b0, 1'b1);
    i_ckt.level(1'b0, 1'b0);
    rchk("kept", udc_pkg::OFS_COUNT, 32'h2);
  endtask
  task automatic t_ext;
    wr(udc_pkg::OFS_CTRL, 32'h3);
    @(posedge clk_in) on_ext_in <= 32'hFFFFFFFB;
    rchk("ext low", udc_pkg::OFS_ON, 32'h0);
    @(posedge clk_in) on_ext_in <= 32'h001E8480;
    rchk("ext high", udc_pkg::OFS_ON, 32'h000F423F);
    sw(1'b0);
    @(posedge clk_in) on_ext_in <= 32'h00000001;
    sw(1'b1);
    rchk("stat on", udc_pkg::OFS_STATUS, 32'h1);
    wr(udc_pkg::OFS_CTRL, 32'h7);
    @(posedge clk_in) off_ext_in <= 32'h00000002;
    rchk("ext off", udc_pkg::OFS_OFF, 32'h2);
    sw(1'b0);
  endtask
  // ==========================================================
  // Verdict and main sequence
  task automatic report_and_stop;
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    miscompares = 0;
    compares    = 0;
    rst_in      = 1'b1;
    wr_in       = 1'b0;
    rd_in       = 1'b0;
    addr_in     = 8'h00;
    wdata_in    = 32'h0;
    on_ext_in   = 32'h00000000;
    off_ext_in  = 32'h00000000;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_count();
    t_hyst();
    t_window();
    t_clear();
    t_pfail();
    t_ext();
    report_and_stop();
  end
endmodule // udc_counter_tb
`default_nettype wire
